// ==== hw/bat_pkg.sv ====
// Constants, types and helpers shared by the bus auto transfer logic.
// Assumes a single 250 MHz clock domain and a plain register port.
package bat_pkg;

    // ----------------------------------------------------------------
    // Widths and roles
    // ----------------------------------------------------------------
    localparam int BAT_ADDR_W = 8;
    localparam int BAT_DATA_W = 32;
    localparam int BAT_DLY_W = 16;

    typedef enum logic [1:0] {
        BAT_ROLE_OFF = 2'b00,
        BAT_ROLE_INC1 = 2'b01,
        BAT_ROLE_INC2 = 2'b10,
        BAT_ROLE_TIE = 2'b11
    } bat_role_t;

    typedef enum logic [1:0] {
        BAT_ST_IDLE = 2'b00,
        BAT_ST_TRIP = 2'b01,
        BAT_ST_REQ = 2'b10,
        BAT_ST_DONE = 2'b11
    } bat_state_t;

    // ----------------------------------------------------------------
    // Register map, fields and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] BAT_OFF_CTRL = 8'h00;
    localparam logic [7:0] BAT_OFF_DLY_THIS = 8'h04;
    localparam logic [7:0] BAT_OFF_DLY_OTHER = 8'h08;
    localparam logic [7:0] BAT_OFF_DLY_SEL = 8'h0c;
    localparam logic [7:0] BAT_OFF_STATUS = 8'h10;
    localparam int BAT_CTRL_ROLE_LSB = 0;
    localparam int BAT_CTRL_SCHEME_BIT = 2;
    localparam int BAT_CTRL_DBL_BIT = 3;
    localparam logic [1:0] BAT_ROLE_RST = 2'h0;
    localparam logic BAT_SCHEME_RST = 1'b0;
    localparam logic BAT_DBL_RST = 1'b0;
    localparam logic [15:0] BAT_DLY_THIS_RST = 16'h0064;
    localparam logic [15:0] BAT_DLY_OTHER_RST = 16'h0064;
    localparam logic [15:0] BAT_DLY_SEL_RST = 16'h0064;

    // ----------------------------------------------------------------
    // Timing: delays count in ticks of one millisecond
    // ----------------------------------------------------------------
    localparam int BAT_CLK_PERIOD_NS = 4;
    localparam int BAT_TICK_NS = 1000000;
    localparam int BAT_TICK_CYC = BAT_TICK_NS / BAT_CLK_PERIOD_NS;

    // Delay counter step: clears when its start condition drops
    function automatic logic [BAT_DLY_W-1:0] bat_tmr_next(
        input logic run,
        input logic tick,
        input logic [BAT_DLY_W-1:0] cnt,
        input logic [BAT_DLY_W-1:0] lim
    );
        if (!run) begin
            return '0;
        end else if (tick && (cnt < lim)) begin
            return cnt + 1'b1;
        end
        return cnt;
    endfunction : bat_tmr_next

endpackage : bat_pkg

// ==== hw/bat_xfer.sv ====
// Bus auto transfer logic for one of three cooperating relays.
// Assumes all field pins are asynchronous levels, active high, and that
// the selected role matches the breaker this relay is wired to.
// How it works
// R1 - Transfer trips own incomer, then closes tie
// R2 - Transformer lockout starts a transfer
// R3 - Upstream source trip starts a transfer
// R4 - Timed undervoltage on own source starts transfer
// R5 - Any breaker not connected blocks initiation
// R6 - Other incomer open blocks initiation
// R7 - Instantaneous overcurrent on own bus blocks initiation
// R8 - Other source instantaneous undervoltage blocks initiation
// R9 - Any blocking condition shows transfer not ready
// R10 - Trip own breaker first, then request tie close
// R11 - Trip held until own breaker reports open
// R12 - Tie latches request until closed or blocked
// R13 - Tie close waits for synchrocheck permission
// R14 - Three closed breakers trip the selected one
// R15 - Role setting: off, incomer 1, incomer 2, tie
// R16 - Scheme select, default first, same everywhere
// R17 - Overcurrent reset opens undervoltage blocking window
// R18 - After double loss, delay blocks initiation
// R19 - Double loss trips only when block disabled
// R20 - Double loss never requests a tie close
// R21 - Select-to-trip delay starts on listed conditions
// R22 - Outputs self-reset, de-energised when not operated
// R23 - Delays count common ticks, restart on drop
`timescale 1ns/10ps
module bat_xfer #(
    parameter int TICK_CYC = bat_pkg::BAT_TICK_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Register port
    input wire logic [bat_pkg::BAT_ADDR_W-1:0] reg_addr,
    input wire logic [bat_pkg::BAT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bat_pkg::BAT_DATA_W-1:0] reg_rdata,
    // Breaker position pins
    input wire logic inc1_conn,
    input wire logic inc2_conn,
    input wire logic tie_conn,
    input wire logic inc1_closed,
    input wire logic inc2_closed,
    input wire logic tie_closed,
    // Source and protection element pins
    input wire logic transformer_lockout_input,
    input wire logic src_trip_in,
    input wire logic uv_timed_own,
    input wire logic uv_inst_own,
    input wire logic uv_inst_other,
    input wire logic phase_overcurrent_instant,
    input wire logic neutral_overcurrent_instant,
    // Scheme control pins
    input wire logic block_xfer_in,
    input wire logic sel_trip_in,
    input wire logic close_req_in,
    input wire logic sync_permit_in,
    // Scheme outputs
    output logic trip_out,
    output logic close_req_out,
    output logic tie_close_out,
    output logic xfer_not_ready
);
    import bat_pkg::*;

    localparam int NPIN = 19;
    localparam int TW = $clog2(TICK_CYC + 1);

    if (TICK_CYC < 1) begin : g_tick_chk
        $error("TICK_CYC must be at least 1");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;

    assign pin_raw = {inc1_conn, inc2_conn, tie_conn, inc1_closed,
        inc2_closed, tie_closed, transformer_lockout_input, src_trip_in,
        uv_timed_own, uv_inst_own, uv_inst_other, phase_overcurrent_instant,
        neutral_overcurrent_instant, block_xfer_in, sel_trip_in,
        close_req_in, sync_permit_in, 2'b00};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic s_c1, s_c2, s_ct, s_k1, s_k2, s_kt, s_lock, s_srct, s_uvt;
    logic s_uvi, s_uvo, s_poc, s_noc, s_blk, s_sel, s_creq, s_sync;
    assign {s_c1, s_c2, s_ct, s_k1, s_k2, s_kt, s_lock, s_srct, s_uvt,
        s_uvi, s_uvo, s_poc, s_noc, s_blk, s_sel, s_creq,
        s_sync} = sync2_reg[NPIN-1:2];

    // ----------------------------------------------------------------
    // Settings registers
    // ----------------------------------------------------------------
    bat_role_t role_reg;
    logic scheme_reg;
    logic dbl_block_reg;
    logic [BAT_DLY_W-1:0] dly_this_reg;
    logic [BAT_DLY_W-1:0] dly_other_reg;
    logic [BAT_DLY_W-1:0] dly_sel_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            role_reg <= bat_role_t'(BAT_ROLE_RST);
            scheme_reg <= BAT_SCHEME_RST; // R16
            dbl_block_reg <= BAT_DBL_RST;
            dly_this_reg <= BAT_DLY_THIS_RST;
            dly_other_reg <= BAT_DLY_OTHER_RST;
            dly_sel_reg <= BAT_DLY_SEL_RST;
        end else if (reg_wr) begin
            if (reg_addr == BAT_OFF_CTRL) begin
                role_reg <= bat_role_t'(reg_wdata[BAT_CTRL_ROLE_LSB +: 2]);
                scheme_reg <= reg_wdata[BAT_CTRL_SCHEME_BIT]; // R16
                dbl_block_reg <= reg_wdata[BAT_CTRL_DBL_BIT];
            end else if (reg_addr == BAT_OFF_DLY_THIS) begin
                dly_this_reg <= reg_wdata[BAT_DLY_W-1:0];
            end else if (reg_addr == BAT_OFF_DLY_OTHER) begin
                dly_other_reg <= reg_wdata[BAT_DLY_W-1:0];
            end else if (reg_addr == BAT_OFF_DLY_SEL) begin
                dly_sel_reg <= reg_wdata[BAT_DLY_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Common delay tick
    // ----------------------------------------------------------------
    logic [TW-1:0] tick_cnt_reg;
    logic tick_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TW'(TICK_CYC - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1; // R23
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Role mapping and blocking conditions
    // ----------------------------------------------------------------
    logic is_inc, is_tie, own_conn, own_closed, other_closed;
    logic oc, dbl_loss, start, uv_block, blk_cond, sel_cond;
    logic this_armed_reg, both_lost_reg, this_done, other_done, sel_done;
    logic [BAT_DLY_W-1:0] this_cnt_reg, other_cnt_reg, sel_cnt_reg;

    // Only the two incomer roles and the tie role carry logic
    assign is_inc = (role_reg == BAT_ROLE_INC1) ||
        (role_reg == BAT_ROLE_INC2); // R15
    assign is_tie = (role_reg == BAT_ROLE_TIE); // R15
    assign own_conn = (role_reg == BAT_ROLE_INC1) ? s_c1 : s_c2;
    assign own_closed = (role_reg == BAT_ROLE_INC1) ? s_k1 :
        (role_reg == BAT_ROLE_INC2) ? s_k2 : s_kt;
    assign other_closed = (role_reg == BAT_ROLE_INC1) ? s_k2 : s_k1;
    assign oc = s_poc | s_noc;
    assign dbl_loss = s_uvt & s_uvo;
    assign start = s_lock | s_srct | s_uvt; // R2 R3 R4
    // Own undervoltage blocks during a fault and for a while after it
    assign this_done = this_armed_reg && !oc && (this_cnt_reg >= dly_this_reg);
    assign uv_block = s_uvi && (oc || (this_armed_reg && !this_done)); // R17
    assign blk_cond = !(s_c1 && s_c2 && s_ct) // R5
        || !other_closed // R6
        || oc // R7
        || s_uvo // R8
        || uv_block // R17
        || both_lost_reg // R18
        || s_blk;
    // An incomer relay with its own breaker open can still be selected to trip; the tie role needs all three closed
    assign sel_cond = is_inc ? (own_conn && other_closed && s_ct && s_kt &&
        s_sel && !s_blk) : (is_tie && s_k1 && s_k2 && s_ct && s_kt &&
        s_sel && !s_blk); // R21
    assign other_done = other_cnt_reg >= dly_other_reg;
    assign sel_done = sel_cond && (sel_cnt_reg >= dly_sel_reg);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            this_armed_reg <= 1'b0;
            this_cnt_reg <= '0;
        end else begin
            this_armed_reg <= oc || (this_armed_reg && !this_done); // R17
            this_cnt_reg <= bat_tmr_next(this_armed_reg && !oc, tick_reg,
                this_cnt_reg, dly_this_reg); // R23
        end
    end

    // Other-source delay runs from the first source returning
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            both_lost_reg <= 1'b0;
            other_cnt_reg <= '0;
        end else begin
            both_lost_reg <= dbl_loss || (both_lost_reg && !other_done); // R18
            other_cnt_reg <= bat_tmr_next(both_lost_reg && !dbl_loss,
                tick_reg, other_cnt_reg, dly_other_reg); // R23
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_cnt_reg <= '0;
        end else begin
            sel_cnt_reg <= bat_tmr_next(sel_cond, tick_reg, sel_cnt_reg,
                dly_sel_reg); // R23
        end
    end

    // ----------------------------------------------------------------
    // Incomer sequence
    // ----------------------------------------------------------------
    bat_state_t state_reg;
    logic xfer_reg, trip_reg, close_req_reg, par_trip_reg;
    logic init_go, dbl_trip;

    assign init_go = is_inc && !blk_cond && start; // R2 R3 R4
    assign dbl_trip = is_inc && dbl_loss && !dbl_block_reg; // R19

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= BAT_ST_IDLE;
            xfer_reg <= 1'b0;
        end else begin
            case (state_reg)
                BAT_ST_IDLE: begin
                    if (init_go || dbl_trip) begin
                        state_reg <= BAT_ST_TRIP; // R1
                        xfer_reg <= init_go && !dbl_loss; // R20
                    end
                end
                BAT_ST_TRIP: begin
                    state_reg <= xfer_reg ? BAT_ST_REQ : BAT_ST_DONE; // R10
                end
                BAT_ST_REQ: begin
                    if (s_kt || s_blk || dbl_loss) begin
                        state_reg <= BAT_ST_DONE;
                    end
                end
                default: begin
                    if (!start && !trip_reg) begin
                        state_reg <= BAT_ST_IDLE;
                        xfer_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Trip stays up while the breaker still reports closed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            trip_reg <= 1'b0;
        end else if (state_reg == BAT_ST_IDLE && (init_go || dbl_trip)) begin
            trip_reg <= 1'b1; // R10
        end else if (trip_reg && !own_closed) begin
            trip_reg <= 1'b0; // R11
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            close_req_reg <= 1'b0;
        end else if (s_kt || s_blk || dbl_loss) begin
            close_req_reg <= 1'b0; // R20
        end else if (state_reg == BAT_ST_TRIP && xfer_reg) begin
            close_req_reg <= 1'b1; // R10
        end else if (state_reg != BAT_ST_REQ) begin
            close_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            par_trip_reg <= 1'b0;
        end else begin
            par_trip_reg <= sel_done; // R14
        end
    end

    // ----------------------------------------------------------------
    // Tie sequence
    // ----------------------------------------------------------------
    logic latch_reg, tie_close_reg;

    // A request seen while the tie already reads closed is dropped
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            latch_reg <= 1'b0;
        end else if (!is_tie || s_kt || s_blk) begin
            latch_reg <= 1'b0; // R12
        end else if (s_creq) begin
            latch_reg <= 1'b1; // R12
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tie_close_reg <= 1'b0;
        end else begin
            tie_close_reg <= is_tie && latch_reg && s_sync && !s_kt; // R13
        end
    end

    // ----------------------------------------------------------------
    // Outputs and register reads
    // ----------------------------------------------------------------
    logic not_ready_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            not_ready_reg <= 1'b0;
        end else begin
            not_ready_reg <= (is_inc && blk_cond) ||
                (is_tie && (!(s_c1 && s_c2 && s_ct) || s_blk)); // R9
        end
    end

    // Plain levels, no hand reset: trip until own breaker opens or sel_done drops, close request until tie closed, block or double loss
    assign trip_out = trip_reg | par_trip_reg; // R22
    assign close_req_out = close_req_reg; // R22
    assign tie_close_out = tie_close_reg; // R22
    assign xfer_not_ready = not_ready_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == BAT_OFF_CTRL) begin
            reg_rdata <= {28'h0, dbl_block_reg, scheme_reg, role_reg};
        end else if (reg_addr == BAT_OFF_DLY_THIS) begin
            reg_rdata <= {16'h0, dly_this_reg};
        end else if (reg_addr == BAT_OFF_DLY_OTHER) begin
            reg_rdata <= {16'h0, dly_other_reg};
        end else if (reg_addr == BAT_OFF_DLY_SEL) begin
            reg_rdata <= {16'h0, dly_sel_reg};
        end else if (reg_addr == BAT_OFF_STATUS) begin
            reg_rdata <= {22'h0, state_reg, both_lost_reg, latch_reg,
                tie_close_reg, par_trip_reg, close_req_reg, trip_reg,
                not_ready_reg, this_armed_reg};
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_trip_held: assert property ( // R11
        trip_reg && own_closed |=> trip_reg)
        else $error("trip dropped while breaker closed");
    chk_req_after_trip: assert property ( // R10
        $rose(close_req_reg) |-> $past(trip_reg))
        else $error("close request before trip");
    chk_start_init: assert property ( // R2
        state_reg == BAT_ST_IDLE && init_go |=> trip_reg && xfer_reg
        ##1 state_reg == BAT_ST_REQ)
        else $error("start did not begin transfer");
    chk_block_init: assert property ( // R5
        state_reg == BAT_ST_IDLE && blk_cond |=> !xfer_reg)
        else $error("transfer begun while blocked");
    chk_not_ready: assert property ( // R9
        is_inc && blk_cond |=> xfer_not_ready)
        else $error("not ready missing");
    chk_latch_hold: assert property ( // R12
        latch_reg && is_tie && !s_kt && !s_blk |=> latch_reg)
        else $error("tie request lost");
    chk_close_perm: assert property ( // R13
        tie_close_out |-> $past(s_sync) && $past(latch_reg))
        else $error("tie close without permission");
    chk_dbl_no_req: assert property ( // R20
        dbl_loss |=> !close_req_out)
        else $error("close request on double loss");
    chk_dbl_suppress: assert property ( // R19
        state_reg == BAT_ST_IDLE && dbl_loss && dbl_block_reg && !trip_reg
        |=> !trip_reg)
        else $error("trip on double loss while suppressed");
    chk_par_cause: assert property ( // R14
        $rose(par_trip_reg) |-> $past(sel_cond) && $past(sel_done))
        else $error("parallel trip without cause");
    chk_off_quiet: assert property ( // R15
        role_reg == BAT_ROLE_OFF && !trip_reg |=> !trip_reg)
        else $error("trip while scheme off");

    cov_transfer: cover property (
        state_reg == BAT_ST_TRIP ##1 close_req_out);
    cov_tie_close: cover property (latch_reg ##[1:20] tie_close_out);
    cov_par_trip: cover property ($rose(par_trip_reg));
    cov_dbl_trip: cover property (dbl_trip && state_reg == BAT_ST_IDLE);

endmodule : bat_xfer

// ==== dv/bat_brk_model.sv ====
// Breaker mechanism model for the own incomer and the bus tie.
// Assumes trip and close commands are held levels from the relay.
`timescale 1ns/10ps
module bat_brk_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Commands
    input wire logic trip_cmd,
    input wire logic close_cmd,
    input wire logic own_set,
    input wire logic tie_set,
    input wire logic tie_clr,
    // Status contacts
    output logic own_closed,
    output logic tie_closed
);
    logic [2:0] trip_cnt_reg;
    logic [2:0] close_cnt_reg;
    // Mechanisms lag the command, so a dropped hold shows up
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            trip_cnt_reg <= 3'h0;
            own_closed <= 1'b0;
        end else begin
            trip_cnt_reg <= trip_cmd ? trip_cnt_reg + 3'h1 : 3'h0;
            if (own_set) begin
                own_closed <= 1'b1;
            end else if (trip_cnt_reg == 3'h5) begin
                own_closed <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            close_cnt_reg <= 3'h0;
            tie_closed <= 1'b0;
        end else begin
            close_cnt_reg <= close_cmd ? close_cnt_reg + 3'h1 : 3'h0;
            if (tie_clr) begin
                tie_closed <= 1'b0;
            end else if (tie_set || close_cnt_reg == 3'h3) begin
                tie_closed <= 1'b1;
            end
        end
    end
endmodule : bat_brk_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the bus auto transfer logic.
// Assumes one clock; the model stands in for the own incomer and the tie.
`timescale 1ns/10ps
module tb_top;
    import bat_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic inc2_conn = 1'b1;
    logic inc2_closed = 1'b1;
    logic own_closed, tie_closed;
    logic lockout = 1'b0, src_trip = 1'b0, uvt = 1'b0, uvi = 1'b0;
    logic uvo = 1'b0, poc = 1'b0, noc = 1'b0, blk_in = 1'b0;
    logic sel = 1'b0, creq = 1'b0, perm = 1'b0;
    logic own_set = 1'b0, tie_set = 1'b0, tie_clr = 1'b0;
    logic trip_out, close_req_out, tie_close_out, xfer_not_ready;
    logic [3:0] outs;
    int num_errors = 0;
    int check_count = 0;
    assign outs = {xfer_not_ready, tie_close_out, close_req_out, trip_out};
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    bat_xfer #(.TICK_CYC(4)) bat_xfer_inst (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .inc1_conn(1'b1), .inc2_conn(inc2_conn),
        .tie_conn(1'b1), .inc1_closed(own_closed),
        .inc2_closed(inc2_closed), .tie_closed(tie_closed),
        .transformer_lockout_input(lockout), .src_trip_in(src_trip),
        .uv_timed_own(uvt), .uv_inst_own(uvi), .uv_inst_other(uvo),
        .phase_overcurrent_instant(poc),
        .neutral_overcurrent_instant(noc), .block_xfer_in(blk_in),
        .sel_trip_in(sel), .close_req_in(creq), .sync_permit_in(perm),
        .trip_out(trip_out), .close_req_out(close_req_out),
        .tie_close_out(tie_close_out), .xfer_not_ready(xfer_not_ready));
    bat_brk_model bat_brk_model_inst (
        .ref_clk(ref_clk), .resetn(resetn), .trip_cmd(trip_out),
        .close_cmd(tie_close_out), .own_set(own_set),
        .tie_set(tie_set), .tie_clr(tie_clr),
        .own_closed(own_closed), .tie_closed(tie_closed));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check("reg_rdata", reg_rdata, exp);
    endtask : rd
    // Output k must keep value v for n cycles
    task automatic hold(input int k, input logic v, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            check("outs", outs[k], v);
        end
        @(posedge ref_clk);
    endtask : hold
    // Bounded wait; running out counts and ends the run
    task automatic wait_sig(input int k, input logic v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge ref_clk);
            if (outs[k] === v) begin
                check("outs", outs[k], v);
                return;
            end
        end
        num_errors++;
        $display("MISMATCH wait outs expected %h seen %h", v, outs[k]);
        report_and_stop();
    endtask : wait_sig
    task automatic pulse(input int k);
        @(posedge ref_clk);
        own_set <= (k == 0);
        tie_set <= (k == 1);
        tie_clr <= (k == 2);
        @(posedge ref_clk);
        own_set <= 1'b0;
        tie_set <= 1'b0;
        tie_clr <= 1'b0;
    endtask : pulse
    task automatic blk(input int i, input logic v);
        case (i)
            0: inc2_conn <= !v;
            1: inc2_closed <= !v;
            2: poc <= v;
            3: noc <= v;
            4: uvo <= v;
            default: blk_in <= v;
        endcase
    endtask : blk
    // Close the tie to retire the request, then reopen the tie and reclose the own incomer
    task automatic rearm;
        pulse(1);
        wait_sig(1, 1'b0, 10);
        pulse(2);
        pulse(0);
    endtask : rearm
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        check("outs", outs, 4'h0);
        rd(BAT_OFF_CTRL, 32'h0);
        rd(BAT_OFF_DLY_THIS, 32'h64);
        rd(BAT_OFF_DLY_OTHER, 32'h64);
        rd(BAT_OFF_DLY_SEL, 32'h64);
        rd(8'h20, 32'h0);
        wr(BAT_OFF_CTRL, 32'h5);
        rd(BAT_OFF_CTRL, 32'h5);
        wr(BAT_OFF_CTRL, 32'h0);
        pulse(0);
        src_trip <= 1'b1;
        hold(0, 1'b0, 10);
        src_trip <= 1'b0;
        wr(BAT_OFF_DLY_SEL, 32'h2);
        wr(BAT_OFF_CTRL, 32'h1);
        repeat (4) @(posedge ref_clk);
        lockout <= 1'b1;
        wait_sig(0, 1'b1, 10);
        check("close_req", close_req_out, 1'b0);
        wait_sig(1, 1'b1, 3);
        wait_sig(0, 1'b0, 20);
        check("own_closed", own_closed, 1'b0);
        @(posedge ref_clk);
        lockout <= 1'b0;
        hold(1, 1'b1, 4);
        pulse(1);
        wait_sig(1, 1'b0, 10);
        pulse(0);
        sel <= 1'b1;
        hold(0, 1'b0, 4);
        wait_sig(0, 1'b1, 40);
        @(posedge ref_clk);
        sel <= 1'b0;
        wait_sig(0, 1'b0, 8);
        pulse(2);
        pulse(0);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            blk(i, 1'b1);
            wait_sig(3, 1'b1, 6);
            @(posedge ref_clk);
            src_trip <= 1'b1;
            hold(0, 1'b0, 8);
            @(posedge ref_clk);
            blk(i, 1'b0);
            src_trip <= 1'b0;
            repeat (6) @(posedge ref_clk);
        end
        wr(BAT_OFF_CTRL, 32'h2);
        src_trip <= 1'b1;
        wait_sig(0, 1'b1, 10);
        @(posedge ref_clk);
        inc2_closed <= 1'b0;
        src_trip <= 1'b0;
        wait_sig(0, 1'b0, 8);
        rearm();
        inc2_closed <= 1'b1;
        wr(BAT_OFF_CTRL, 32'h1);
        poc <= 1'b1;
        repeat (4) @(posedge ref_clk);
        poc <= 1'b0;
        uvi <= 1'b1;
        hold(3, 1'b1, 20);
        wait_sig(3, 1'b0, 600);
        @(posedge ref_clk);
        uvi <= 1'b0;
        uvt <= 1'b1;
        wait_sig(0, 1'b1, 10);
        @(posedge ref_clk);
        uvt <= 1'b0;
        wait_sig(0, 1'b0, 20);
        rearm();
        wr(BAT_OFF_CTRL, 32'h9);
        uvo <= 1'b1;
        uvt <= 1'b1;
        hold(0, 1'b0, 20);
        uvo <= 1'b0;
        uvt <= 1'b0;
        src_trip <= 1'b1;
        hold(0, 1'b0, 10);
        wait_sig(0, 1'b1, 1000);
        @(posedge ref_clk);
        src_trip <= 1'b0;
        wait_sig(0, 1'b0, 20);
        rearm();
        wr(BAT_OFF_CTRL, 32'h1);
        uvo <= 1'b1;
        uvt <= 1'b1;
        wait_sig(0, 1'b1, 10);
        hold(1, 1'b0, 10);
        uvo <= 1'b0;
        uvt <= 1'b0;
        wr(BAT_OFF_CTRL, 32'h3);
        pulse(2);
        creq <= 1'b1;
        hold(2, 1'b0, 8);
        creq <= 1'b0;
        hold(2, 1'b0, 4);
        perm <= 1'b1;
        wait_sig(2, 1'b1, 6);
        wait_sig(2, 1'b0, 12);
        check("tie_closed", tie_closed, 1'b1);
        pulse(2);
        blk_in <= 1'b1;
        creq <= 1'b1;
        hold(2, 1'b0, 8);
        creq <= 1'b0;
        blk_in <= 1'b0;
        hold(2, 1'b0, 8);
        report_and_stop();
    end
endmodule : tb_top
